// File: common/sdi_defs.vh
// Register map, field positions, reset values and timing counts of the stepper driver interface
`ifndef SDI_DEFS_VH
`define SDI_DEFS_VH
`define SDI_ADDR_CONTROL_SOURCE 7'h00
`define SDI_ADDR_RUN 7'h01
`define SDI_ADDR_CONST_PHASE_MODE 7'h07
`define SDI_ADDR_STEP_COUNT_LOW 7'h08
`define SDI_ADDR_STEP_COUNT_HIGH 7'h09
`define SDI_ADDR_DRIVER_INIT_CFG 7'h10
`define SDI_ADDR_DRIVER_OUT_CTRL 7'h11
`define SDI_ADDR_VCLK_RATIO 7'h12
`define SDI_ADDR_STATUS 7'h20
`define SDI_ADDR_VSTEP_COUNT 7'h21
`define SDI_ADDR_PHASE 7'h22
`define SDI_RST_BYTE 8'h00
`define SDI_RST_BIT 1'b0
`define SDI_RST_RATIO 6'h00
`define SDI_RST_STEP_COUNT 9'h000
`define SDI_CFG_RESET_POLARITY 7
`define SDI_CFG_RESET_PHASE_SELECT 6
`define SDI_CFG_RESET_PHASE_ADJUST 5
`define SDI_CFG_OUTPUT_ENABLE_CONTROL 4
`define SDI_CFG_OUTPUT_ENABLE_POLARITY 3
`define SDI_CFG_STEP_WHILE_DISABLED 2
`define SDI_CFG_FAMILY_MSB 1
`define SDI_CFG_FAMILY_LSB 0
`define SDI_OUT_EFFICIENCY 7
`define SDI_OUT_SLEEP 6
`define SDI_OUT_DRIVER_RESET 5
`define SDI_OUT_OUTPUT_ENABLE 4
`define SDI_OUT_DIRECTION 3
`define SDI_OUT_EXC_MSB 2
`define SDI_OUT_EXC_LSB 0
`define SDI_RAMP_STEPS 8'd16
`define SDI_STEP_VTICKS 8'd4
`define SDI_PHASE_315 6'h38
`define SDI_PHASE_0 6'h00
`define SDI_EXC_TABLE_FAM0 32'h32ba1098
`define SDI_EXC_TABLE_FAM1 32'h3210cba9
`define SDI_EXC_TABLE_FAM2 32'h42103210
`define SDI_EXC_TABLE_FAM3 32'h12102110
`endif

// File: rtl/sdi_stepper_driver_config.v
// Stepper driver interface: serial register file, run sequencer, driver pin control and phase tracking
`timescale 1ns/1ns
`default_nettype none
`include "sdi_defs.vh"
module sdi_stepper_driver_config (
  input wire clock,
  input wire rst_n,
  input wire spiCs_n,
  input wire spiSck,
  input wire spiMosi,
  output reg spiMiso,
  input wire startPin,
  input wire stepInPin,
  input wire efficiencyEnablePin,
  output reg efficiencyEnableOut,
  output reg driverResetOut,
  output reg stepPulseOut,
  input wire directionPinIn,
  output reg directionPinOut,
  output reg directionPinDrive_n,
  input wire [2:0] excitationSelectPinsIn,
  output reg [2:0] excitationSelectPinsOut,
  output reg excitationSelectPinsDrive_n,
  input wire driverSleepPinIn,
  output reg driverSleepPinOut,
  output reg driverSleepPinDrive_n,
  input wire outputEnablePinIn,
  output reg outputEnablePinOut,
  output reg outputEnablePinDrive_n
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_ACCEL = 5'b00010;
  localparam ST_CONST = 5'b00100;
  localparam ST_DECEL = 5'b01000;
  localparam ST_DONE = 5'b10000;

  reg controlSourceSelect_reg;
  reg runBit_reg;
  reg constantPhaseMode_reg;
  reg [8:0] constantStepCount_reg;
  reg [7:0] driverInitialConfig_reg;
  reg [7:0] driverOutputControl_reg;
  reg [5:0] virtualClockRatio_reg;
  reg [4:0] state_reg;
  reg [7:0] rampCnt_reg;
  reg [8:0] constCnt_reg;
  reg [5:0] ratioAcc_reg;
  reg [7:0] stepTimer_reg;
  reg runPrev_reg;
  reg stepInPrev_reg;
  reg [5:0] phase_reg;
  reg [2:0] vstepSub_reg;
  reg [7:0] vstepCount_reg;
  reg sckPrev_reg;
  reg [4:0] bitCnt_reg;
  reg [14:0] shiftIn_reg;
  reg [7:0] readLatch_reg;

  wire registerMode = controlSourceSelect_reg;
  wire resetPolarity = driverInitialConfig_reg[`SDI_CFG_RESET_POLARITY];
  wire resetPhaseSelect = driverInitialConfig_reg[`SDI_CFG_RESET_PHASE_SELECT];
  wire resetPhaseAdjust = driverInitialConfig_reg[`SDI_CFG_RESET_PHASE_ADJUST];
  wire outputEnableControl = driverInitialConfig_reg[`SDI_CFG_OUTPUT_ENABLE_CONTROL];
  wire outputEnablePolarity = driverInitialConfig_reg[`SDI_CFG_OUTPUT_ENABLE_POLARITY];
  wire stepWhileDisabled = driverInitialConfig_reg[`SDI_CFG_STEP_WHILE_DISABLED];
  wire [1:0] driverFamilySelect = driverInitialConfig_reg[`SDI_CFG_FAMILY_MSB:`SDI_CFG_FAMILY_LSB];
  wire sleepOutputBit = driverOutputControl_reg[`SDI_OUT_SLEEP];
  wire resetOutputBit = driverOutputControl_reg[`SDI_OUT_DRIVER_RESET];
  wire enableOutputBit = driverOutputControl_reg[`SDI_OUT_OUTPUT_ENABLE];
  wire directionBit = driverOutputControl_reg[`SDI_OUT_DIRECTION];
  wire [2:0] excitationSelectBits = driverOutputControl_reg[`SDI_OUT_EXC_MSB:`SDI_OUT_EXC_LSB];

  // Start source and inputs that the driver shares with the host
  wire runSource = registerMode ? runBit_reg : startPin;
  wire directionNow = registerMode ? directionBit : directionPinIn;
  wire [2:0] excitationCode = registerMode ? excitationSelectBits : excitationSelectPinsIn;
  wire enableLevel = registerMode ? enableOutputBit :
                     (outputEnableControl ? driverSleepPinIn : outputEnablePinIn);
  wire outputsEnabled = enableLevel ^ outputEnablePolarity;

  // Excitation lookup: per code a nibble {both edges, resolution 0 full .. 4 sixteenth}
  reg [31:0] excTable;
  always @* begin
    case (driverFamilySelect)
      2'h0: excTable = `SDI_EXC_TABLE_FAM0;
      2'h1: excTable = `SDI_EXC_TABLE_FAM1;
      2'h2: excTable = `SDI_EXC_TABLE_FAM2;
      default: excTable = `SDI_EXC_TABLE_FAM3;
    endcase
  end
  wire [3:0] excEntry = excTable[{excitationCode, 2'b00} +: 4];
  wire bothEdges = excEntry[3];
  wire [2:0] resolution = excEntry[2:0];
  wire [5:0] phaseStep = 6'h10 >> resolution;
  wire [2:0] kLog = (resolution == 3'd0) ? 3'd0 : resolution - 3'd1;
  wire [2:0] kLast = (3'd1 << kLog) - 3'd1;

  // Virtual clock: ratio/64 of the device clock, taken as the carry of an accumulator
  wire [6:0] ratioSum = {1'b0, ratioAcc_reg} + {1'b0, virtualClockRatio_reg};
  wire virtualTick = ratioSum[6];
  wire moving = (state_reg == ST_ACCEL) || (state_reg == ST_CONST) || (state_reg == ST_DECEL);
  wire stepTick = moving && virtualTick && (stepTimer_reg == `SDI_STEP_VTICKS - 8'd1);

  // Phase tracking: issued steps act as rising edges; incoming pulses follow the edge mode
  wire inRise = stepInPin && !stepInPrev_reg;
  wire inFall = !stepInPin && stepInPrev_reg;
  wire stepEvent = stepTick || inRise || (bothEdges && inFall);
  wire phaseMayMove = outputsEnabled || stepWhileDisabled;
  wire resetRequest = registerMode && resetOutputBit;
  wire [5:0] phaseTarget = (resetPhaseSelect && resolution != 3'd0) ? `SDI_PHASE_0 : `SDI_PHASE_315;
  // Unipolar drivers resume on the excitation grid, so the reset phase is snapped to it
  wire [5:0] phaseReset = resetPhaseAdjust ? (phaseTarget & ~(phaseStep - 6'd1)) : phaseTarget;

  // Serial port: 16-bit frames, MSB first, {write, address[6:0], data[7:0]}
  wire sckRise = spiSck && !sckPrev_reg;
  wire sckFall = !spiSck && sckPrev_reg;
  wire [6:0] wrAddr = shiftIn_reg[13:7];
  wire [7:0] wrData = {shiftIn_reg[6:0], spiMosi};
  wire writeNow = !spiCs_n && sckRise && (bitCnt_reg == 5'd15) && shiftIn_reg[14];
  reg [7:0] readData;
  always @* begin
    case (shiftIn_reg[6:0])
      `SDI_ADDR_CONTROL_SOURCE: readData = {7'h00, controlSourceSelect_reg};
      `SDI_ADDR_RUN: readData = {7'h00, runBit_reg};
      `SDI_ADDR_CONST_PHASE_MODE: readData = {7'h00, constantPhaseMode_reg};
      `SDI_ADDR_STEP_COUNT_LOW: readData = constantStepCount_reg[7:0];
      `SDI_ADDR_STEP_COUNT_HIGH: readData = {7'h00, constantStepCount_reg[8]};
      `SDI_ADDR_DRIVER_INIT_CFG: readData = driverInitialConfig_reg;
      `SDI_ADDR_DRIVER_OUT_CTRL: readData = driverOutputControl_reg;
      `SDI_ADDR_VCLK_RATIO: readData = {2'b00, virtualClockRatio_reg};
      `SDI_ADDR_STATUS: readData = {3'b000, state_reg};
      `SDI_ADDR_VSTEP_COUNT: readData = vstepCount_reg;
      `SDI_ADDR_PHASE: readData = {2'b00, phase_reg};
      default: readData = `SDI_RST_BYTE;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      sckPrev_reg <= 1'b0;
      bitCnt_reg <= 5'd0;
      shiftIn_reg <= 15'h0000;
      readLatch_reg <= `SDI_RST_BYTE;
      spiMiso <= 1'b0;
      controlSourceSelect_reg <= `SDI_RST_BIT;
      runBit_reg <= `SDI_RST_BIT;
      constantPhaseMode_reg <= `SDI_RST_BIT;
      constantStepCount_reg <= `SDI_RST_STEP_COUNT;
      driverInitialConfig_reg <= `SDI_RST_BYTE;
      driverOutputControl_reg <= `SDI_RST_BYTE;
      virtualClockRatio_reg <= `SDI_RST_RATIO;
    end else begin
      sckPrev_reg <= spiSck;
      if (spiCs_n) begin
        bitCnt_reg <= 5'd0;
      end else if (sckRise && bitCnt_reg != 5'd16) begin
        shiftIn_reg <= {shiftIn_reg[13:0], spiMosi};
        bitCnt_reg <= bitCnt_reg + 5'd1;
      end else if (sckFall && bitCnt_reg == 5'd8) begin
        readLatch_reg <= readData;
        spiMiso <= readData[7];
      end else if (sckFall && bitCnt_reg > 5'd8 && bitCnt_reg < 5'd16) begin
        spiMiso <= readLatch_reg[3'd7 - bitCnt_reg[2:0]];
      end
      if (writeNow) begin
        case (wrAddr)
          `SDI_ADDR_CONTROL_SOURCE: controlSourceSelect_reg <= wrData[0];
          `SDI_ADDR_RUN: runBit_reg <= wrData[0];
          `SDI_ADDR_CONST_PHASE_MODE: constantPhaseMode_reg <= wrData[0];
          `SDI_ADDR_STEP_COUNT_LOW: constantStepCount_reg[7:0] <= wrData;
          `SDI_ADDR_STEP_COUNT_HIGH: constantStepCount_reg[8] <= wrData[0];
          `SDI_ADDR_DRIVER_INIT_CFG: driverInitialConfig_reg <= wrData;
          `SDI_ADDR_DRIVER_OUT_CTRL: driverOutputControl_reg <= wrData;
          `SDI_ADDR_VCLK_RATIO: virtualClockRatio_reg <= wrData[5:0];
          default: ;
        endcase
      end
    end
  end

  // Run sequencer; ramps are fixed step counts since curve data is held elsewhere
  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      runPrev_reg <= 1'b0;
      rampCnt_reg <= 8'd0;
      constCnt_reg <= 9'd0;
      ratioAcc_reg <= 6'h00;
      stepTimer_reg <= 8'd0;
      stepPulseOut <= 1'b0;
    end else begin
      runPrev_reg <= runSource;
      ratioAcc_reg <= ratioSum[5:0];
      stepPulseOut <= stepTick;
      if (!moving) begin
        stepTimer_reg <= 8'd0;
      end else if (virtualTick) begin
        stepTimer_reg <= stepTick ? 8'd0 : stepTimer_reg + 8'd1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (runSource && !runPrev_reg) begin
            state_reg <= ST_ACCEL;
            rampCnt_reg <= 8'd0;
          end
        end
        ST_ACCEL: begin
          if (stepTick) begin
            rampCnt_reg <= rampCnt_reg + 8'd1;
            if (rampCnt_reg == `SDI_RAMP_STEPS - 8'd1) begin
              state_reg <= ST_CONST;
              constCnt_reg <= 9'd0;
            end
          end
        end
        ST_CONST: begin
          if (!runSource) begin
            state_reg <= ST_DECEL;
            rampCnt_reg <= 8'd0;
          end else if (stepTick) begin
            constCnt_reg <= constCnt_reg + 9'd1;
            // A zero count matches only when the 9-bit count wraps after 512 steps, which is why the host must not program it
            if (constantPhaseMode_reg && constCnt_reg + 9'd1 == constantStepCount_reg) begin
              state_reg <= ST_DECEL;
              rampCnt_reg <= 8'd0;
            end
          end
        end
        ST_DECEL: begin
          if (stepTick) begin
            rampCnt_reg <= rampCnt_reg + 8'd1;
            if (rampCnt_reg == `SDI_RAMP_STEPS - 8'd1) begin
              state_reg <= runSource ? ST_DONE : ST_IDLE;
            end
          end
        end
        ST_DONE: begin
          if (!runSource) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Phase and virtual step count
  always @(posedge clock) begin
    if (!rst_n) begin
      stepInPrev_reg <= 1'b0;
      phase_reg <= `SDI_PHASE_315;
      vstepSub_reg <= 3'd0;
      vstepCount_reg <= 8'd0;
    end else begin
      stepInPrev_reg <= stepInPin;
      if (resetRequest) begin
        phase_reg <= phaseReset;
      end else if (stepEvent && phaseMayMove) begin
        phase_reg <= directionNow ? phase_reg + phaseStep : phase_reg - phaseStep;
      end
      if (stepEvent) begin
        // One virtual step per excitation factor of real steps
        if (vstepSub_reg >= kLast) begin
          vstepSub_reg <= 3'd0;
          vstepCount_reg <= vstepCount_reg + 8'd1;
        end else begin
          vstepSub_reg <= vstepSub_reg + 3'd1;
        end
      end
    end
  end

  // Driver pins, all registered; in pin-driven control the shared pins go to the host, except enable when output enable control is set
  always @(posedge clock) begin
    if (!rst_n) begin
      efficiencyEnableOut <= 1'b0;
      driverResetOut <= 1'b1;
      directionPinOut <= 1'b0;
      directionPinDrive_n <= 1'b1;
      excitationSelectPinsOut <= 3'b000;
      excitationSelectPinsDrive_n <= 1'b1;
      driverSleepPinOut <= 1'b0;
      driverSleepPinDrive_n <= 1'b1;
      outputEnablePinOut <= 1'b0;
      outputEnablePinDrive_n <= 1'b1;
    end else begin
      efficiencyEnableOut <= driverOutputControl_reg[`SDI_OUT_EFFICIENCY] | efficiencyEnablePin;
      driverResetOut <= resetRequest ? resetPolarity : ~resetPolarity;
      directionPinOut <= directionBit;
      directionPinDrive_n <= ~registerMode;
      excitationSelectPinsOut <= excitationSelectBits;
      excitationSelectPinsDrive_n <= ~registerMode;
      driverSleepPinOut <= sleepOutputBit;
      driverSleepPinDrive_n <= ~registerMode;
      outputEnablePinOut <= registerMode ? enableOutputBit : driverSleepPinIn;
      outputEnablePinDrive_n <= ~(registerMode | outputEnableControl);
    end
  end
endmodule
`default_nettype wire

// File: bench/sdi_checker_sva.sv
// Port-level assertions for the stepper driver interface
`timescale 1ns/1ns
`default_nettype none
module sdi_checker_sva (
  input wire clock,
  input wire rst_n,
  input wire spiSck,
  input wire spiMiso,
  input wire efficiencyEnablePin,
  input wire efficiencyEnableOut,
  input wire driverResetOut,
  input wire stepPulseOut,
  input wire directionPinDrive_n,
  input wire excitationSelectPinsDrive_n,
  input wire driverSleepPinDrive_n,
  input wire outputEnablePinDrive_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_RESET_STATE: assert property ($rose(rst_n) |-> driverResetOut && !stepPulseOut && directionPinDrive_n)
    else $error("driver pins not idle after reset");
  AST_EFFICIENCY_OR: assert property ($past(rst_n) && $past(efficiencyEnablePin) |-> efficiencyEnableOut)
    else $error("efficiency pin request not forwarded");
  AST_STEP_SPACING: assert property (stepPulseOut |=> !stepPulseOut [*3])
    else $error("step pulses closer than four virtual ticks");
  AST_DRIVE_GROUP: assert property (directionPinDrive_n == excitationSelectPinsDrive_n
    && directionPinDrive_n == driverSleepPinDrive_n)
    else $error("driver pin groups disagree on control source");
  AST_OE_DRIVE: assert property (!directionPinDrive_n |-> !outputEnablePinDrive_n)
    else $error("enable pin released in register mode");
  AST_MISO_CHANGE: assert property ($changed(spiMiso) |-> !spiSck)
    else $error("serial output moved while serial clock high");
  AST_DRIVE_AFTER_WRITE: assert property ($changed(directionPinDrive_n)
    |-> $past(spiSck, 2) || $past(spiSck, 3) || $past(spiSck, 4))
    else $error("control source changed without a serial write");
  AST_RESET_OUT_AFTER_WRITE: assert property ($changed(driverResetOut)
    |-> $past(spiSck, 2) || $past(spiSck, 3) || $past(spiSck, 4))
    else $error("driver reset moved without a serial write");
  CVR_STEP: cover property (stepPulseOut);
  CVR_REG_MODE: cover property (!directionPinDrive_n);
  CVR_RESET_LOW: cover property (!driverResetOut);
endmodule
bind sdi_stepper_driver_config sdi_checker_sva chk (.clock, .rst_n, .spiSck, .spiMiso, .efficiencyEnablePin,
  .efficiencyEnableOut, .driverResetOut, .stepPulseOut, .directionPinDrive_n, .excitationSelectPinsDrive_n,
  .driverSleepPinDrive_n, .outputEnablePinDrive_n);
`default_nettype wire

// File: bench/sdi_driver_model.sv
// Driver-side model: resolves the shared control pins and counts step pulses
`timescale 1ns/1ns
`default_nettype none
module sdi_driver_model (
  input wire clock,
  input wire stepPulseOut,
  input wire dirOut,
  input wire dirDrv_n,
  input wire [2:0] excOut,
  input wire excDrv_n,
  input wire slpOut,
  input wire slpDrv_n,
  input wire oeOut,
  input wire oeDrv_n,
  output wire dirW,
  output wire [2:0] excW,
  output wire slpW,
  output wire oeW,
  output wire [15:0] stepTotal
);
  reg wiggle = 1'b0;
  reg [15:0] count = 16'h0000;
  // Released lines toggle so a stale level never passes for a driven one
  always @(posedge clock) begin
    wiggle <= ~wiggle;
    if (stepPulseOut) count <= count + 16'h0001;
  end
  assign dirW = dirDrv_n ? wiggle : dirOut;
  assign excW = excDrv_n ? {3{wiggle}} : excOut;
  assign slpW = slpDrv_n ? ~wiggle : slpOut;
  assign oeW = oeDrv_n ? wiggle : oeOut;
  assign stepTotal = count;
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench: register access, driver pins and run sequencing
`timescale 1ns/1ns
`default_nettype none
`include "sdi_defs.vh"
module testbench;
  reg clock = 0, rst_n = 0, spiCs_n = 1, spiSck = 0, spiMosi = 0, effPin = 0, startIn = 0, stepIn = 0;
  wire spiMiso, effOut, drvRst, stepOut, dirOut, dirDrv_n, excDrv_n, slpOut, slpDrv_n, oeOut, oeDrv_n;
  wire dirW, slpW, oeW;
  wire [2:0] excOut, excW;
  wire [15:0] stepTotal;
  reg [7:0] rd, v, w;
  reg [15:0] s0;
  reg [7:0] expQ[$], obsQ[$];
  string nameQ[$];
  event obsEvt;
  integer bad_count = 0, checks_done = 0, cycles = 0, j;
  always #4 clock = ~clock;
  sdi_stepper_driver_config uut (.clock(clock), .rst_n(rst_n), .spiCs_n(spiCs_n), .spiSck(spiSck),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .startPin(startIn), .stepInPin(stepIn), .efficiencyEnablePin(effPin),
    .efficiencyEnableOut(effOut), .driverResetOut(drvRst), .stepPulseOut(stepOut), .directionPinIn(dirW),
    .directionPinOut(dirOut), .directionPinDrive_n(dirDrv_n), .excitationSelectPinsIn(excW),
    .excitationSelectPinsOut(excOut), .excitationSelectPinsDrive_n(excDrv_n), .driverSleepPinIn(slpW),
    .driverSleepPinOut(slpOut), .driverSleepPinDrive_n(slpDrv_n), .outputEnablePinIn(oeW),
    .outputEnablePinOut(oeOut), .outputEnablePinDrive_n(oeDrv_n));
  sdi_driver_model drv (.clock(clock), .stepPulseOut(stepOut), .dirOut(dirOut), .dirDrv_n(dirDrv_n),
    .excOut(excOut), .excDrv_n(excDrv_n), .slpOut(slpOut), .slpDrv_n(slpDrv_n), .oeOut(oeOut),
    .oeDrv_n(oeDrv_n), .dirW(dirW), .excW(excW), .slpW(slpW), .oeW(oeW), .stepTotal(stepTotal));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  task cmp(input string n, input [7:0] e, input [7:0] s);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  // Drains every pending note, since two notes in one time step raise only one wake-up
  always @(obsEvt) begin
    while (expQ.size() > 0) cmp(nameQ.pop_front(), expQ.pop_front(), obsQ.pop_front());
  end
  task note(input string n, input [7:0] e, input [7:0] s);
    begin
      expQ.push_back(e);
      nameQ.push_back(n);
      obsQ.push_back(s);
      ->obsEvt;
    end
  endtask
  task pulse;
    begin
      stepIn = 1;
      repeat (3) @(negedge clock);
      stepIn = 0;
      repeat (3) @(negedge clock);
    end
  endtask
  task frame(input [15:0] f);
    integer b;
    begin
      @(negedge clock);
      spiCs_n = 0;
      for (b = 15; b >= 0; b = b - 1) begin
        spiSck = 0;
        spiMosi = f[b];
        repeat (3) @(negedge clock);
        if (b < 8) rd[b] = spiMiso;
        spiSck = 1;
        repeat (2) @(negedge clock);
      end
      spiSck = 0;
      repeat (3) @(negedge clock);
      spiCs_n = 1;
      repeat (2) @(negedge clock);
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    frame({1'b1, a, d});
  endtask
  task rdchk(input string n, input [6:0] a, input [7:0] e);
    begin
      frame({1'b0, a, 8'h00});
      note(n, e, rd);
    end
  endtask
  task waitStatus(input [7:0] s);
    integer k;
    begin
      rd = 8'h00;
      for (k = 0; k < 100 && rd !== s; k = k + 1) frame({1'b0, `SDI_ADDR_STATUS, 8'h00});
    end
  endtask
  function [7:0] maskOf(input [6:0] a);
    maskOf = (a == 7'h07 || a == 7'h09) ? 8'h01 : (a == 7'h12) ? 8'h3f : 8'hff;
  endfunction
  function [6:0] addrOf(input integer i);
    addrOf = (i < 3) ? 7'h07 + i[6:0] : 7'h0d + i[6:0];
  endfunction
  initial begin
    v = $urandom(32'hdf3e4753);
    repeat (20) @(negedge clock);
    rst_n = 1;
    for (j = 0; j < 6; j = j + 1) rdchk("reset value", addrOf(j), 8'h00);
    rdchk("unmapped", 7'h05, 8'h00);
    for (j = 0; j < 6; j = j + 1) begin
      v = $urandom;
      wr(addrOf(j), v);
      rdchk("readback", addrOf(j), v & maskOf(addrOf(j)));
    end
    wr(`SDI_ADDR_STATUS, 8'hff);
    rdchk("read-only status", `SDI_ADDR_STATUS, 8'h01);
    wr(`SDI_ADDR_CONTROL_SOURCE, 8'h01);
    for (j = 0; j < 6; j = j + 1) begin
      v = $urandom;
      w = $urandom;
      w[6] = w[5];
      effPin = v[0];
      wr(`SDI_ADDR_DRIVER_INIT_CFG, {v[7], 7'h00});
      wr(`SDI_ADDR_DRIVER_OUT_CTRL, w);
      note("driver pins", {w[5] ? v[7] : ~v[7], w[6], w[3], w[2:0], w[7] | v[0], 1'b0},
        {drvRst, slpOut, dirOut, excOut, effOut, dirDrv_n});
      note("drive enables", {4'h0, w[4], 3'b000}, {4'h0, oeOut, excDrv_n, slpDrv_n, oeDrv_n});
    end
    wr(`SDI_ADDR_CONTROL_SOURCE, 8'h00);
    note("pin mode", {3'h0, 4'hf, ~v[7]}, {3'h0, dirDrv_n, excDrv_n, slpDrv_n, oeDrv_n, drvRst});
    wr(`SDI_ADDR_DRIVER_INIT_CFG, 8'h10);
    note("enable pin output", 8'h00, {7'h00, oeDrv_n});
    wr(`SDI_ADDR_CONTROL_SOURCE, 8'h01);
    wr(`SDI_ADDR_DRIVER_INIT_CFG, 8'h00);
    wr(`SDI_ADDR_DRIVER_OUT_CTRL, 8'h10);
    wr(`SDI_ADDR_VCLK_RATIO, 8'h20);
    wr(`SDI_ADDR_CONST_PHASE_MODE, 8'h01);
    wr(`SDI_ADDR_STEP_COUNT_LOW, 8'h01);
    wr(`SDI_ADDR_STEP_COUNT_HIGH, 8'h01);
    s0 = stepTotal;
    wr(`SDI_ADDR_RUN, 8'h01);
    waitStatus(8'h10);
    rdchk("counted run done", `SDI_ADDR_STATUS, 8'h10);
    note("counted steps", 8'h21, stepTotal[7:0] - s0[7:0]);
    wr(`SDI_ADDR_RUN, 8'h00);
    rdchk("idle after clear", `SDI_ADDR_STATUS, 8'h01);
    wr(`SDI_ADDR_CONST_PHASE_MODE, 8'h00);
    wr(`SDI_ADDR_RUN, 8'h01);
    waitStatus(8'h04);
    repeat (400) @(negedge clock);
    rdchk("constant run", `SDI_ADDR_STATUS, 8'h04);
    wr(`SDI_ADDR_RUN, 8'h00);
    waitStatus(8'h01);
    rdchk("stop after decel", `SDI_ADDR_STATUS, 8'h01);
    wr(`SDI_ADDR_DRIVER_OUT_CTRL, 8'h21);
    rdchk("reset phase 315", `SDI_ADDR_PHASE, 8'h38);
    wr(`SDI_ADDR_DRIVER_INIT_CFG, 8'h40);
    rdchk("reset phase 0", `SDI_ADDR_PHASE, 8'h00);
    wr(`SDI_ADDR_DRIVER_INIT_CFG, 8'h20);
    wr(`SDI_ADDR_DRIVER_OUT_CTRL, 8'h22);
    rdchk("reset phase adjusted", `SDI_ADDR_PHASE, 8'h30);
    wr(`SDI_ADDR_DRIVER_OUT_CTRL, 8'h00);
    pulse;
    rdchk("disabled ignores steps", `SDI_ADDR_PHASE, 8'h30);
    wr(`SDI_ADDR_DRIVER_INIT_CFG, 8'h04);
    pulse;
    rdchk("disabled steps advance", `SDI_ADDR_PHASE, 8'h10);
    wr(`SDI_ADDR_DRIVER_INIT_CFG, 8'h08);
    pulse;
    rdchk("low-active enable", `SDI_ADDR_PHASE, 8'h30);
    wr(`SDI_ADDR_CONTROL_SOURCE, 8'h00);
    startIn = 1;
    waitStatus(8'h04);
    rdchk("pin start", `SDI_ADDR_STATUS, 8'h04);
    startIn = 0;
    waitStatus(8'h01);
    rdchk("pin stop", `SDI_ADDR_STATUS, 8'h01);
    @(negedge clock);
    summarize;
  end
endmodule
`default_nettype wire
